/* File: test/pwm_timer_clock_and_counter_control_tb.sv */
// Self-checking testbench for the PWM timer clock and counter control slice.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, ac); end end
module pwm_timer_clock_and_counter_control_tb;
    import pwm_timer_pkg::*;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, got, d;
    logic [4:0] osc = 5'h00; // Pins: external, 256 Hz, slow, fast B, fast A.
    logic tick, run, clr, one_shot, cbuf, half;
    int n_mismatch = 0, n_checks = 0, n_tick = 0, pin;
    pwm_timer_clock_and_counter_control uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fast_osc_a(osc[0]), .fast_osc_b(osc[1]), .slow_osc(osc[2]),
        .regulated_256hz_clock(osc[3]), .ext_clock(osc[4]), .count_tick(tick), .counter_run(run),
        .counter_clear(clr), .one_shot_select(one_shot), .compare_buffer_en(cbuf), .half_clock_mode_en(half));
    // Free-running 10 MHz clock, and a tally of count ticks.
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (tick === 1'b1) n_tick <= n_tick + 1;
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // Unusable codes and a closed gate give no ticks; code 9 on the slow source is undivided.
    function automatic int exp_ticks(input int src, input int code, input int gate, input int edges);
        if (gate == 0 || code > ((src == 1) ? 9 : 14)) return 0;
        return (src == 1 && code == 9) ? edges : edges >> code;
    endfunction
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        int cs_src[8] = '{0, 1, 2, 3, 1, 1, 0, 0};
        int cs_code[8] = '{0, 1, 1, 0, 9, 10, 15, 0};
        void'($urandom(29));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd_reg(TIMER_COUNTER_CONTROL_ADDR, got);
        `CHK("ctl_reset", 16'h0000, got)
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 16'hffff : 16'($urandom);
            wr_reg(TIMER_COUNTER_CONTROL_ADDR, d);
            @(negedge clk);
            `CHK("clear", d[1], clr)
            `CHK("levels", {d[6], d[3:2], d[0]}, {half, cbuf, one_shot, run})
            rd_reg(TIMER_COUNTER_CONTROL_ADDR, got);
            `CHK("ctl_read", d & 16'h004d, got)
            d = (i == 0) ? 16'h00ff : 16'($urandom);
            wr_reg(TIMER_CLOCK_CONTROL_ADDR, d);
            rd_reg(TIMER_CLOCK_CONTROL_ADDR, got);
            `CHK("clk_read", d & 16'h00fd, got)
            rd_reg(16'h5402, got);
            `CHK("unmapped", 16'h0000, got)
        end
        $display("Register test done");
        // Closing the gate first restarts the prescaler phase for each case.
        for (int i = 0; i < 8; i++) begin
            wr_reg(TIMER_CLOCK_CONTROL_ADDR, 16'h0000);
            wr_reg(TIMER_CLOCK_CONTROL_ADDR, 16'(cs_code[i] * 16 + cs_src[i] * 4 + (i < 7)));
            pin = (cs_src[i] == 0) ? 1 : (cs_src[i] == 2) ? 0 : (cs_src[i] == 3) ? 4 : (cs_code[i] == 9) ? 3 : 2;
            n_tick = 0;
            repeat (4) begin
                repeat (3) @(posedge clk);
                osc[pin] <= 1'b1;
                repeat (3) @(posedge clk);
                osc[pin] <= 1'b0;
            end
            repeat (6) @(posedge clk);
            `CHK("ticks", exp_ticks(cs_src[i], cs_code[i], (i < 7), 4), n_tick)
        end
        $display("Tick test done");
        end_sim();
    end
endmodule
`default_nettype wire

/* File: test/pwm_timer_ctl_props.sv */
// Concurrent checks on the PWM timer control slice ports.
`timescale 1ns/100ps
`default_nettype none
module pwm_timer_ctl_props (
    input wire logic clk, // Clock.
    input wire logic reset, // Reset.
    input wire logic [pwm_timer_pkg::ADDR_W-1:0] addr, // Address.
    input wire logic [pwm_timer_pkg::DATA_W-1:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    input wire logic [pwm_timer_pkg::DATA_W-1:0] rdata, // Read data.
    input wire logic count_tick, // Tick.
    input wire logic counter_run, // Run.
    input wire logic counter_clear, // Clear.
    input wire logic one_shot_select, // Mode.
    input wire logic compare_buffer_en, // Buffer.
    input wire logic half_clock_mode_en // Half clock.
);
    import pwm_timer_pkg::*;
    wire logic ctl_wr;
    wire logic any_rd;
    wire logic [15:0] ctl_view;
    // Decoded strobes and the readable image of the counter control levels.
    assign ctl_wr = wr && addr == TIMER_COUNTER_CONTROL_ADDR;
    assign any_rd = rd && (addr == TIMER_COUNTER_CONTROL_ADDR || addr == TIMER_CLOCK_CONTROL_ADDR);
    assign ctl_view = {9'h000, half_clock_mode_en, 2'h0, compare_buffer_en, one_shot_select, 1'b0, counter_run};
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_clear_req;
        ctl_wr && wdata[COUNTER_CLEAR_BIT];
    endsequence
    chk_clear_pulse:
    assert property (s_clear_req |=> counter_clear) else $error("clear pulse missing");
    chk_clear_cause:
    assert property (counter_clear |-> $past(ctl_wr && wdata[COUNTER_CLEAR_BIT])) else $error("stray clear pulse");
    chk_ctl_levels:
    assert property (ctl_wr |=> ctl_view == ($past(wdata) & 16'h004d)) else $error("control levels wrong");
    chk_levels_hold:
    assert property (!ctl_wr |=> $stable(ctl_view)) else $error("control levels moved");
    chk_read_ctl:
    assert property (rd && addr == TIMER_COUNTER_CONTROL_ADDR |=> rdata == $past(ctl_view)) else $error("control read");
    chk_read_mask:
    assert property ($past(any_rd) |-> rdata[15:8] == 8'h00 && !rdata[1]) else $error("reserved bits set");
    chk_read_idle:
    assert property (!$past(any_rd) |-> rdata == 16'h0000) else $error("read data not zero");
    chk_tick_single:
    assert property (count_tick |=> !count_tick) else $error("tick too long");
endmodule
bind pwm_timer_clock_and_counter_control pwm_timer_ctl_props chk (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_tick(count_tick), .counter_run(counter_run),
    .counter_clear(counter_clear), .one_shot_select(one_shot_select), .compare_buffer_en(compare_buffer_en),
    .half_clock_mode_en(half_clock_mode_en));
`default_nettype wire

/* File: verilog/clock_edge_sync.sv */
// Two-flop synchroniser with rising-edge detector for one asynchronous clock input.
`timescale 1ns/100ps
`default_nettype none
module clock_edge_sync (
    input wire logic clk, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic async_in, // Level from outside the clock domain.
    output logic rise // One-cycle pulse on a synchronised rising edge.
);
    logic meta;
    logic sync;
    logic last;

    // The first flop feeds only the second; edges are found on the settled copy.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= async_in;
            sync <= meta;
            last <= sync;
        end
    end

    assign rise = sync & ~last;
endmodule
`default_nettype wire

/* File: verilog/pwm_timer_clock_and_counter_control.sv */
// PWM timer channel clock selection, prescaler, gating and counter control registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Fast source divides by two to prescale code
// - Slow source: codes 0-8 divide, 9 picks 256Hz
// - Source code 3 external, code 0 fast B
// - Gate bit passes prescaled clock, reset blocks
// - Half clock mode bit, reset disabled
// - Compare buffer enable bit, reset disabled
// - Count mode: 1 one-shot, 0 repeat
// - Clear bit write-only, reads zero
// - Run bit starts or stops counter
// - Reserved bits read as zero
module pwm_timer_clock_and_counter_control (
    input wire logic clk, // System clock, 10 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [pwm_timer_pkg::ADDR_W-1:0] addr, // Register byte address.
    input wire logic [pwm_timer_pkg::DATA_W-1:0] wdata, // Write data.
    input wire logic wr, // Write strobe, one cycle.
    input wire logic rd, // Read strobe, one cycle.
    output logic [pwm_timer_pkg::DATA_W-1:0] rdata, // Read data, valid the cycle after rd.
    input wire logic fast_osc_a, // First high-frequency oscillator clock.
    input wire logic fast_osc_b, // Second high-frequency oscillator clock.
    input wire logic slow_osc, // Low-frequency oscillator clock.
    input wire logic regulated_256hz_clock, // Regulated 256 Hz clock.
    input wire logic ext_clock, // External count clock pin.
    output logic count_tick, // One-cycle pulse per gated count clock.
    output logic counter_run, // Counter runs while high.
    output logic counter_clear, // One-cycle pulse clearing the counter.
    output logic one_shot_select, // High for one-shot, low for repeat.
    output logic compare_buffer_en, // Compare values are buffered while high.
    output logic half_clock_mode_en // Half-clock mode enabled while high.
);
    import pwm_timer_pkg::*;

    logic [PRESCALE_W-1:0] prescale_code;
    logic [SOURCE_W-1:0] clock_source_code;
    logic count_clock_gate;
    logic [DIV_W-1:0] div_count;
    logic [DIV_W-1:0] next_div_count;
    logic rise_fast_a;
    logic rise_fast_b;
    logic rise_slow;
    logic rise_256;
    logic rise_ext;
    logic src_tick;
    logic slow_selected;
    logic use_256hz;
    logic code_legal;
    logic [DIV_W:0] div_mask;
    logic div_done;
    logic pre_tick;
    logic sel_clock;
    logic sel_counter;
    logic wr_clock;
    logic wr_counter;
    logic [DATA_W-1:0] clock_readback;
    logic [DATA_W-1:0] counter_readback;
    logic [DATA_W-1:0] next_rdata;

    // Each asynchronous clock is resampled; the fast oscillators must run below half of clk.
    clock_edge_sync sync_fast_a (
        .clk(clk),
        .reset(reset),
        .async_in(fast_osc_a),
        .rise(rise_fast_a)
    );
    clock_edge_sync sync_fast_b (
        .clk(clk),
        .reset(reset),
        .async_in(fast_osc_b),
        .rise(rise_fast_b)
    );
    clock_edge_sync sync_slow (
        .clk(clk),
        .reset(reset),
        .async_in(slow_osc),
        .rise(rise_slow)
    );
    clock_edge_sync sync_256 (
        .clk(clk),
        .reset(reset),
        .async_in(regulated_256hz_clock),
        .rise(rise_256)
    );
    clock_edge_sync sync_ext (
        .clk(clk),
        .reset(reset),
        .async_in(ext_clock),
        .rise(rise_ext)
    );

    // Source selection; the external code bypasses nothing and still goes through the prescaler.
    assign src_tick = (clock_source_code == SRC_EXTERNAL) ? rise_ext :
                      (clock_source_code == SRC_FAST_OSC_B) ? rise_fast_b :
                      (clock_source_code == SRC_SLOW_OSC) ? rise_slow : rise_fast_a;
    assign slow_selected = (clock_source_code == SRC_SLOW_OSC);
    assign use_256hz = slow_selected && (prescale_code == SLOW_256HZ_CODE);
    // Unusable codes stop the count clock rather than guess a ratio.
    assign code_legal = slow_selected ? (prescale_code <= SLOW_256HZ_CODE) : (prescale_code <= FAST_MAX_CODE);
    // Divide by 2^code: a tick whenever the low code bits of the counter are all ones.
    assign div_mask = ({{DIV_W{1'b0}}, 1'b1} << prescale_code) - {{DIV_W{1'b0}}, 1'b1};
    assign div_done = ((div_count & div_mask[DIV_W-1:0]) == div_mask[DIV_W-1:0]);
    assign pre_tick = use_256hz ? rise_256 : (src_tick && div_done);
    assign next_div_count = (!count_clock_gate || use_256hz) ? '0 :
                            src_tick ? (div_count + {{(DIV_W-1){1'b0}}, 1'b1}) : div_count;

    // Prescaler counter and gated tick; the counter is held cleared while the gate is shut.
    always_ff @(posedge clk) begin
        if (reset) begin
            div_count <= '0;
            count_tick <= 1'b0;
        end else begin
            div_count <= next_div_count;
            count_tick <= count_clock_gate && code_legal && pre_tick;
        end
    end

    // Register decode.
    assign sel_clock = (addr == TIMER_CLOCK_CONTROL_ADDR);
    assign sel_counter = (addr == TIMER_COUNTER_CONTROL_ADDR);
    assign wr_clock = wr && sel_clock;
    assign wr_counter = wr && sel_counter;

    // Clock control register writes.
    always_ff @(posedge clk) begin
        if (reset) begin
            prescale_code <= TIMER_CLOCK_CONTROL_RESET[PRESCALE_LSB +: PRESCALE_W];
            clock_source_code <= TIMER_CLOCK_CONTROL_RESET[SOURCE_LSB +: SOURCE_W];
            count_clock_gate <= TIMER_CLOCK_CONTROL_RESET[CLOCK_GATE_BIT];
        end else if (wr_clock) begin
            prescale_code <= wdata[PRESCALE_LSB +: PRESCALE_W];
            clock_source_code <= wdata[SOURCE_LSB +: SOURCE_W];
            count_clock_gate <= wdata[CLOCK_GATE_BIT];
        end
    end

    // Counter control register writes; the clear bit is a pulse and keeps no state.
    always_ff @(posedge clk) begin
        if (reset) begin
            half_clock_mode_en <= TIMER_COUNTER_CONTROL_RESET[HALF_CLOCK_BIT];
            compare_buffer_en <= TIMER_COUNTER_CONTROL_RESET[COMPARE_BUF_BIT];
            one_shot_select <= TIMER_COUNTER_CONTROL_RESET[ONE_SHOT_BIT];
            counter_run <= TIMER_COUNTER_CONTROL_RESET[COUNTER_RUN_BIT];
            counter_clear <= 1'b0;
        end else begin
            counter_clear <= wr_counter && wdata[COUNTER_CLEAR_BIT];
            if (wr_counter) begin
                half_clock_mode_en <= wdata[HALF_CLOCK_BIT];
                compare_buffer_en <= wdata[COMPARE_BUF_BIT];
                one_shot_select <= wdata[ONE_SHOT_BIT];
                counter_run <= wdata[COUNTER_RUN_BIT];
            end
        end
    end

    // Read-back images; reserved bits and the clear bit are tied low.
    always_comb begin
        clock_readback = '0;
        clock_readback[PRESCALE_LSB +: PRESCALE_W] = prescale_code;
        clock_readback[SOURCE_LSB +: SOURCE_W] = clock_source_code;
        clock_readback[CLOCK_GATE_BIT] = count_clock_gate;
        counter_readback = '0;
        counter_readback[HALF_CLOCK_BIT] = half_clock_mode_en;
        counter_readback[COMPARE_BUF_BIT] = compare_buffer_en;
        counter_readback[ONE_SHOT_BIT] = one_shot_select;
        counter_readback[COUNTER_RUN_BIT] = counter_run;
    end

    // Unmapped addresses read zero.
    assign next_rdata = !rd ? '0 : sel_clock ? clock_readback : sel_counter ? counter_readback : '0;

    // Read data register, valid only in the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/pwm_timer_pkg.sv */
// Package with register map, field positions and codes for the PWM timer control slice.
package pwm_timer_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] TIMER_CLOCK_CONTROL_ADDR = 16'h5068;
    localparam logic [15:0] TIMER_COUNTER_CONTROL_ADDR = 16'h5400;
    localparam logic [7:0] TIMER_CLOCK_CONTROL_RESET = 8'h00;
    localparam logic [15:0] TIMER_COUNTER_CONTROL_RESET = 16'h0000;
    // Clock control field positions.
    localparam int PRESCALE_LSB = 4;
    localparam int PRESCALE_W = 4;
    localparam int SOURCE_LSB = 2;
    localparam int SOURCE_W = 2;
    localparam int CLOCK_GATE_BIT = 0;
    // Counter control field positions.
    localparam int HALF_CLOCK_BIT = 6;
    localparam int COMPARE_BUF_BIT = 3;
    localparam int ONE_SHOT_BIT = 2;
    localparam int COUNTER_CLEAR_BIT = 1;
    localparam int COUNTER_RUN_BIT = 0;
    // Clock source codes.
    localparam logic [1:0] SRC_FAST_OSC_B = 2'h0;
    localparam logic [1:0] SRC_SLOW_OSC = 2'h1;
    localparam logic [1:0] SRC_FAST_OSC_A = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL = 2'h3;
    // Prescaler limits.
    localparam logic [3:0] FAST_MAX_CODE = 4'he;
    localparam logic [3:0] SLOW_MAX_CODE = 4'h8;
    localparam logic [3:0] SLOW_256HZ_CODE = 4'h9;
    localparam int DIV_W = 14;
endpackage
